/* File: rtl/ucal_calc.sv */
// Timeout and scale-down timing calculator
`timescale 1ns/10ps
`default_nettype none
module ucal_calc
  import ucal_pkg::*;
#(
  parameter int P_SUSPEND_CYCLES = SUSPEND_CYCLES
) (
  ucal_cfg_if.calc cfg_if
);
  logic [LIMIT_W-1:0] susp_full;
  logic [LIMIT_W-1:0] gen_full;
  logic               susp_sc;
  logic               gen_sc;

  assign susp_full = LIMIT_W'(P_SUSPEND_CYCLES);
  assign gen_full  = LIMIT_W'(BUS_RESET_CYCLES);

  // Only the 60 MHz factors exist; other PHY rates are not supported
  assign cfg_if.hs_timeout = HS_BASE_BITS + (10'(cfg_if.hs_trim) * HS_BITS_PER_CK);
  assign cfg_if.fs_timeout = FS_BASE_TENTHS
                             + (8'(cfg_if.fs_trim) * FS_TENTHS_PER_CK);

  always_comb begin
    susp_sc = 1'b0;
    gen_sc  = 1'b0;
    case (ucal_scale_t'(cfg_if.scale))
      SC_OFF:  susp_sc = 1'b0;
      SC_GEN:  gen_sc = 1'b1;
      SC_SUSP: susp_sc = 1'b1;
      SC_BOTH: begin
        susp_sc = 1'b1;
        gen_sc  = 1'b1;
      end
      default: susp_sc = 1'b0;
    endcase
  end

  assign cfg_if.susp_limit = susp_sc ? (susp_full >> SCALE_SHIFT) : susp_full;
  assign cfg_if.gen_limit  = gen_sc ? (gen_full >> SCALE_SHIFT) : gen_full;
endmodule
`default_nettype wire

/* File: rtl/ucal_cfg_if.sv */
// Interface between the register slave and the timing calculator
`timescale 1ns/10ps
`default_nettype none
interface ucal_cfg_if;
  import ucal_pkg::*;
  logic [2:0]         hs_trim;
  logic [2:0]         fs_trim;
  logic [1:0]         scale;
  logic [9:0]         hs_timeout;
  logic [7:0]         fs_timeout;
  logic [LIMIT_W-1:0] susp_limit;
  logic [LIMIT_W-1:0] gen_limit;
  modport cfg (output hs_trim, fs_trim, scale,
               input  hs_timeout, fs_timeout, susp_limit, gen_limit);
  modport calc (input  hs_trim, fs_trim, scale,
                output hs_timeout, fs_timeout, susp_limit, gen_limit);
endinterface
`default_nettype wire

/* File: rtl/ucal_pkg.sv */
// Offsets, field layout, reset values and timing for the USB timeout trim register
package ucal_pkg;
  localparam logic [11:0] CFG1_OFS       = 12'h084;
  localparam int          HS_TRIM_MSB    = 15;
  localparam int          HS_TRIM_LSB    = 13;
  localparam int          FS_TRIM_MSB    = 6;
  localparam int          FS_TRIM_LSB    = 4;
  localparam int          SCALE_MSB      = 1;
  localparam int          SCALE_LSB      = 0;
  localparam logic [2:0]  TRIM_RST       = 3'h0;
  localparam logic [1:0]  SCALE_RST      = 2'h0;
  // High-speed timeout in bit times; base sits inside the 736..816 window
  localparam logic [9:0]  HS_MIN_BITS    = 10'h2E0;
  localparam logic [9:0]  HS_MAX_BITS    = 10'h330;
  localparam logic [9:0]  HS_BASE_BITS   = 10'h308;
  localparam logic [9:0]  HS_BITS_PER_CK = 10'h008;
  // Full-speed timeout in tenths of a bit time, so 0.2 stays exact
  localparam logic [7:0]  FS_MIN_TENTHS  = 8'hA0;
  localparam logic [7:0]  FS_MAX_TENTHS  = 8'hB4;
  localparam logic [7:0]  FS_BASE_TENTHS = 8'hAA;
  localparam logic [7:0]  FS_TENTHS_PER_CK = 8'h02;
  // Core timing constants and their scaled-down form
  localparam int          CLK_NS         = 25;
  localparam int          CLK_MHZ        = 40;
  localparam int          SUSPEND_US     = 3000;
  localparam int          SUSPEND_CYCLES = SUSPEND_US * CLK_MHZ;
  localparam int          BUS_RESET_NS   = 2500;
  localparam int          BUS_RESET_CYCLES = (BUS_RESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int          LIMIT_W        = 17;
  localparam int          SCALE_SHIFT    = 6;
  typedef enum logic [1:0] {
    SC_OFF  = 2'b00,
    SC_GEN  = 2'b01,
    SC_SUSP = 2'b10,
    SC_BOTH = 2'b11
  } ucal_scale_t;
  typedef enum logic {
    BUS_ACK  = 1'b0,
    BUS_WAIT = 1'b1
  } ucal_bus_t;
endpackage

/* File: rtl/ucal_usb_config_one.sv */
// Avalon-MM register slave for USB inter-packet timeout trim and scale-down
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - HS trim counts PHY clocks, scaled by bit factor, added to HS timeout.
// - Untrimmed HS timeout lies within 736 to 816 bit times.
// - At 60 MHz each HS trim unit adds eight bit times.
// - FS trim counts PHY clocks, scaled by bit factor, added to FS timeout.
// - Untrimmed FS timeout lies within 16 to 18 bit times.
// - At 60 MHz each FS trim unit adds two tenths of a bit.
// - Only the 60 MHz PHY clock factors are implemented.
// - Scale code: 0 real, 1 all but suspend, 2 suspend only, 3 both.
// - Scaled modes swap in shortened timing constants; otherwise full values.
// - Trim power-on default comes from image if present, else zero.
// - Bus reset or lite reset restores trims from last loaded image, or zero if no image is present.
module ucal_usb_config_one
  import ucal_pkg::*;
#(
  parameter int P_SUSPEND_CYCLES = SUSPEND_CYCLES
) (
  input  wire logic               i_ref_clk,
  input  wire logic               i_arst_n,
  input  wire logic [11:0]        i_avm_address,
  input  wire logic               i_avm_read,
  input  wire logic               i_avm_write,
  input  wire logic [31:0]        i_avm_writedata,
  input  wire logic [3:0]         i_avm_byteenable,
  output logic [31:0]             o_avm_readdata,
  output logic                    o_avm_waitrequest,
  input  wire logic               i_image_present,
  input  wire logic               i_image_load,
  input  wire logic [2:0]         i_image_high_speed_trim,
  input  wire logic [2:0]         i_image_full_speed_trim,
  input  wire logic               i_usb_bus_reset,
  input  wire logic               i_lite_reset,
  output logic [9:0]              o_hs_timeout_bits,
  output logic [7:0]              o_fs_timeout_tenths,
  output logic [LIMIT_W-1:0]      o_suspend_limit,
  output logic [LIMIT_W-1:0]      o_general_limit
);
  localparam logic [LIMIT_W-1:0] SUSP_FULL = LIMIT_W'(P_SUSPEND_CYCLES);
  localparam logic [LIMIT_W-1:0] GEN_FULL  = LIMIT_W'(BUS_RESET_CYCLES);

  ucal_bus_t   bus_state_reg;
  ucal_bus_t   bus_state_next;
  logic        boot_reg;
  logic [2:0]  img_hs_reg;
  logic [2:0]  img_hs_next;
  logic [2:0]  img_fs_reg;
  logic [2:0]  img_fs_next;
  logic [2:0]  hs_trim_reg;
  logic [2:0]  hs_trim_next;
  logic [2:0]  fs_trim_reg;
  logic [2:0]  fs_trim_next;
  logic [1:0]  scale_reg;
  logic [1:0]  scale_next;
  logic        sel_cfg;
  logic        wr_hit;
  logic        restore;
  logic [31:0] reg_word;

  ucal_cfg_if cfg_if ();

  ucal_calc #(
    .P_SUSPEND_CYCLES (P_SUSPEND_CYCLES)
  ) u_calc (
    .cfg_if (cfg_if.calc)
  );

  assign cfg_if.hs_trim = hs_trim_reg;
  assign cfg_if.fs_trim = fs_trim_reg;
  assign cfg_if.scale   = scale_reg;

  // Power-on image capture happens one edge after reset release
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      boot_reg <= 1'b1;
    end else begin
      boot_reg <= 1'b0;
    end
  end

  always_comb begin
    img_hs_next = img_hs_reg;
    img_fs_next = img_fs_reg;
    if (boot_reg || i_image_load) begin
      if (i_image_present) begin
        img_hs_next = i_image_high_speed_trim;
        img_fs_next = i_image_full_speed_trim;
      end else begin
        img_hs_next = TRIM_RST;
        img_fs_next = TRIM_RST;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      img_hs_reg <= TRIM_RST;
      img_fs_reg <= TRIM_RST;
    end else begin
      img_hs_reg <= img_hs_next;
      img_fs_reg <= img_fs_next;
    end
  end

  assign restore = boot_reg || i_usb_bus_reset || i_lite_reset;
  assign sel_cfg = (i_avm_address == CFG1_OFS);
  assign wr_hit  = (bus_state_reg == BUS_ACK) && i_avm_write && sel_cfg;

  // Restore beats a software write landing in the same cycle
  always_comb begin
    hs_trim_next = hs_trim_reg;
    fs_trim_next = fs_trim_reg;
    if (restore) begin
      hs_trim_next = img_hs_next;
      fs_trim_next = img_fs_next;
      // A vanished image source means no image at all, whatever was stored
      if (!i_image_present) begin
        hs_trim_next = TRIM_RST;
        fs_trim_next = TRIM_RST;
      end
    end else if (wr_hit) begin
      if (i_avm_byteenable[1]) begin
        hs_trim_next = i_avm_writedata[HS_TRIM_MSB:HS_TRIM_LSB];
      end
      if (i_avm_byteenable[0]) begin
        fs_trim_next = i_avm_writedata[FS_TRIM_MSB:FS_TRIM_LSB];
      end
    end
  end

  // Scale is a debug knob; link resets leave it alone
  always_comb begin
    scale_next = scale_reg;
    if (wr_hit && i_avm_byteenable[0]) begin
      scale_next = i_avm_writedata[SCALE_MSB:SCALE_LSB];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hs_trim_reg <= TRIM_RST;
      fs_trim_reg <= TRIM_RST;
      scale_reg   <= SCALE_RST;
    end else begin
      hs_trim_reg <= hs_trim_next;
      fs_trim_reg <= fs_trim_next;
      scale_reg   <= scale_next;
    end
  end

  always_comb begin
    reg_word = 32'h0000_0000;
    reg_word[HS_TRIM_MSB:HS_TRIM_LSB] = hs_trim_reg;
    reg_word[FS_TRIM_MSB:FS_TRIM_LSB] = fs_trim_reg;
    reg_word[SCALE_MSB:SCALE_LSB] = scale_reg;
  end

  // Every access waits exactly one cycle; waitrequest idles high
  always_comb begin
    bus_state_next = BUS_WAIT;
    case (bus_state_reg)
      BUS_WAIT: begin
        if (i_avm_read || i_avm_write) begin
          bus_state_next = BUS_ACK;
        end
      end
      BUS_ACK:  bus_state_next = BUS_WAIT;
      default:  bus_state_next = BUS_WAIT;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bus_state_reg <= BUS_WAIT;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  assign o_avm_waitrequest = bus_state_reg;

  // Unmapped reads return zero
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avm_readdata <= 32'h0000_0000;
    end else if ((bus_state_reg == BUS_WAIT) && i_avm_read) begin
      o_avm_readdata <= sel_cfg ? reg_word : 32'h0000_0000;
    end
  end

  // Registered so the core sees glitch-free constants
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_hs_timeout_bits   <= HS_BASE_BITS;
      o_fs_timeout_tenths <= FS_BASE_TENTHS;
      o_suspend_limit     <= SUSP_FULL;
      o_general_limit     <= GEN_FULL;
    end else begin
      o_hs_timeout_bits   <= cfg_if.hs_timeout;
      o_fs_timeout_tenths <= cfg_if.fs_timeout;
      o_suspend_limit     <= cfg_if.susp_limit;
      o_general_limit     <= cfg_if.gen_limit;
    end
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking

  default disable iff (!i_arst_n);

  property p_hs_added;
    1'b1 |=> o_hs_timeout_bits == HS_BASE_BITS + {$past(hs_trim_reg), 3'h0};
  endproperty
  a_hs_added: assert property (p_hs_added)
    else $error("HS timeout does not include trim");

  property p_hs_window;
    hs_trim_reg == 3'h0 |=>
      (o_hs_timeout_bits >= HS_MIN_BITS) && (o_hs_timeout_bits <= HS_MAX_BITS);
  endproperty
  a_hs_window: assert property (p_hs_window)
    else $error("Untrimmed HS timeout outside window");

  property p_hs_step;
    hs_trim_reg == 3'h1 |=> o_hs_timeout_bits == HS_BASE_BITS + 10'h008;
  endproperty
  a_hs_step: assert property (p_hs_step)
    else $error("HS trim unit is not eight bit times");

  property p_fs_added;
    1'b1 |=> o_fs_timeout_tenths == FS_BASE_TENTHS + {$past(fs_trim_reg), 1'b0};
  endproperty
  a_fs_added: assert property (p_fs_added)
    else $error("FS timeout does not include trim");

  property p_fs_window;
    fs_trim_reg == 3'h0 |=>
      (o_fs_timeout_tenths >= FS_MIN_TENTHS) && (o_fs_timeout_tenths <= FS_MAX_TENTHS);
  endproperty
  a_fs_window: assert property (p_fs_window)
    else $error("Untrimmed FS timeout outside window");

  property p_fs_step;
    fs_trim_reg == 3'h5 |=> o_fs_timeout_tenths == FS_BASE_TENTHS + 8'h0A;
  endproperty
  a_fs_step: assert property (p_fs_step)
    else $error("Five FS trim units do not add one bit time");

  property p_scale_susp;
    scale_reg == 2'h2 |=>
      (o_suspend_limit == (SUSP_FULL >> SCALE_SHIFT)) && (o_general_limit == GEN_FULL);
  endproperty
  a_scale_susp: assert property (p_scale_susp)
    else $error("Suspend-only scale decoded wrongly");

  property p_scale_gen;
    scale_reg == 2'h1 |=>
      (o_suspend_limit == SUSP_FULL) && (o_general_limit == (GEN_FULL >> SCALE_SHIFT));
  endproperty
  a_scale_gen: assert property (p_scale_gen)
    else $error("General scale decoded wrongly");

  property p_scale_off;
    scale_reg == 2'h0 ##1 scale_reg == 2'h0 |=>
      (o_suspend_limit == SUSP_FULL) && (o_general_limit == GEN_FULL) [*1];
  endproperty
  a_scale_off: assert property (p_scale_off)
    else $error("Full timing not used with scale off");

  property p_boot_blank;
    boot_reg && !i_image_present |=> (hs_trim_reg == 3'h0) && (fs_trim_reg == 3'h0);
  endproperty
  a_boot_blank: assert property (p_boot_blank)
    else $error("Trim not zero without image");

  property p_boot_image;
    boot_reg && i_image_present |=>
      hs_trim_reg == $past(i_image_high_speed_trim)
      && fs_trim_reg == $past(i_image_full_speed_trim);
  endproperty
  a_boot_image: assert property (p_boot_image)
    else $error("Trim not loaded from image");

  property p_restore;
    (i_usb_bus_reset || i_lite_reset) && !boot_reg && !i_image_load && i_image_present |=>
      hs_trim_reg == $past(img_hs_reg) && fs_trim_reg == $past(img_fs_reg);
  endproperty
  a_restore: assert property (p_restore)
    else $error("Link reset did not restore image trim");

  property p_bus_answer;
    (i_avm_read || i_avm_write) && o_avm_waitrequest |=> !o_avm_waitrequest ##1 o_avm_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus answer not one cycle after request");

  property p_restore_blank;
    (i_usb_bus_reset || i_lite_reset) && !i_image_present |=>
      (hs_trim_reg == 3'h0) && (fs_trim_reg == 3'h0);
  endproperty
  a_restore_blank: assert property (p_restore_blank)
    else $error("Link reset without image did not clear trim");

  property p_trim_write;
    wr_hit && !restore && i_avm_byteenable[1] |=>
      hs_trim_reg == $past(i_avm_writedata[HS_TRIM_MSB:HS_TRIM_LSB]);
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("HS trim write did not land");

  property p_fs_write;
    wr_hit && !restore && i_avm_byteenable[0] |=>
      fs_trim_reg == $past(i_avm_writedata[FS_TRIM_MSB:FS_TRIM_LSB])
      && scale_reg == $past(i_avm_writedata[SCALE_MSB:SCALE_LSB]);
  endproperty
  a_fs_write: assert property (p_fs_write)
    else $error("FS trim or scale write did not land");

  // Reserved bits must read zero or software may misread them as settings
  property p_read_reserved;
    !o_avm_waitrequest |->
      (o_avm_readdata[31:16] == 16'h0000) && (o_avm_readdata[12:7] == 6'h00)
      && (o_avm_readdata[3:2] == 2'h0);
  endproperty
  a_read_reserved: assert property (p_read_reserved)
    else $error("Reserved read bits not zero");

  property p_scale_kept;
    (i_usb_bus_reset || i_lite_reset) && !wr_hit |=> scale_reg == $past(scale_reg);
  endproperty
  a_scale_kept: assert property (p_scale_kept)
    else $error("Link reset changed scale field");

  property p_unmapped_write;
    (bus_state_reg == BUS_ACK) && i_avm_write && !sel_cfg && !restore |=>
      $stable(hs_trim_reg) && $stable(fs_trim_reg) && $stable(scale_reg);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write)
    else $error("Unmapped write changed the register");

  property p_scale_both;
    scale_reg == 2'h3 |=>
      (o_suspend_limit == (SUSP_FULL >> SCALE_SHIFT))
      && (o_general_limit == (GEN_FULL >> SCALE_SHIFT));
  endproperty
  a_scale_both: assert property (p_scale_both)
    else $error("Combined scale decoded wrongly");

  c_write_scale: cover property (wr_hit && i_avm_byteenable[0] && i_avm_writedata[1:0] == 2'h3);
  c_restore: cover property (i_lite_reset && !boot_reg ##1 hs_trim_reg != 3'h0);
  c_read_cfg: cover property (i_avm_read && sel_cfg && !o_avm_waitrequest);
  c_both_trims: cover property (hs_trim_reg == 3'h7 && fs_trim_reg == 3'h7);
  c_restore_blank: cover property (i_usb_bus_reset && !i_image_present);
endmodule
`default_nettype wire

/* File: verif/ucal_image_src.sv */
// Behavioural model of the configuration image loader and USB reset sources
`timescale 1ns/10ps
`default_nettype none
module ucal_image_src (
  input  wire logic       i_ref_clk,
  output logic            o_present,
  output logic            o_load,
  output logic [2:0]      o_hs_trim,
  output logic [2:0]      o_fs_trim,
  output logic            o_bus_reset,
  output logic            o_lite_reset
);
  // Power-on image holds non-zero trims so a zero default cannot pass by accident
  initial begin
    o_present    = 1'b1;
    o_load       = 1'b0;
    o_hs_trim    = 3'h5;
    o_fs_trim    = 3'h3;
    o_bus_reset  = 1'b0;
    o_lite_reset = 1'b0;
  end
  task automatic load_image(input logic [2:0] hs, input logic [2:0] fs);
    @(posedge i_ref_clk);
    o_hs_trim <= hs;
    o_fs_trim <= fs;
    o_load    <= 1'b1;
    @(posedge i_ref_clk);
    o_load    <= 1'b0;
  endtask
  // With no image the data lines flip, so only the present flag may decide
  task automatic set_present(input logic p);
    @(posedge i_ref_clk);
    o_present <= p;
    o_hs_trim <= p ? o_hs_trim : ~o_hs_trim;
    o_fs_trim <= p ? o_fs_trim : ~o_fs_trim;
  endtask
  task automatic pulse_reset(input logic lite);
    @(posedge i_ref_clk);
    o_lite_reset <= lite;
    o_bus_reset  <= ~lite;
    @(posedge i_ref_clk);
    o_lite_reset <= 1'b0;
    o_bus_reset  <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/ucal_usb_config_one_tb_top.sv */
// Self-checking bench for the USB timeout trim register
`timescale 1ns/10ps
`default_nettype none
module ucal_usb_config_one_tb_top;
  import ucal_pkg::*;
  localparam int        SUSP = 256;
  logic                 clk = 1'b0;
  logic                 arst_n = 1'b0;
  logic [11:0]          addr = 12'h000;
  logic                 rd = 1'b0;
  logic                 wr = 1'b0;
  logic [31:0]          wd = 32'h0;
  logic [3:0]           be = 4'h0;
  logic [31:0]          rdata;
  logic                 waitreq;
  logic                 im_pres, im_load, bus_rst, lite_rst;
  logic [2:0]           im_hs, im_fs;
  logic [9:0]           hs_to;
  logic [7:0]           fs_to;
  logic [LIMIT_W-1:0]   susp_lim, gen_lim;
  int                   n_fail = 0;
  int                   checks = 0;
  logic [31:0]          q;

  always #12.5 clk = ~clk;

  ucal_usb_config_one #(.P_SUSPEND_CYCLES(SUSP)) i_ucal_usb_config_one (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_avm_address(addr), .i_avm_read(rd),
    .i_avm_write(wr), .i_avm_writedata(wd), .i_avm_byteenable(be),
    .o_avm_readdata(rdata), .o_avm_waitrequest(waitreq), .i_image_present(im_pres),
    .i_image_load(im_load), .i_image_high_speed_trim(im_hs),
    .i_image_full_speed_trim(im_fs), .i_usb_bus_reset(bus_rst), .i_lite_reset(lite_rst),
    .o_hs_timeout_bits(hs_to), .o_fs_timeout_tenths(fs_to),
    .o_suspend_limit(susp_lim), .o_general_limit(gen_lim));

  ucal_image_src i_ucal_image_src (
    .i_ref_clk(clk), .o_present(im_pres), .o_load(im_load), .o_hs_trim(im_hs),
    .o_fs_trim(im_fs), .o_bus_reset(bus_rst), .o_lite_reset(lite_rst));

  function automatic logic [31:0] word(input logic [2:0] hs, fs, input logic [1:0] sc);
    return {16'h0, hs, 6'h0, fs, 2'h0, sc};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low; read data taken at that edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] r);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    addr <= a;
    wd <= d;
    be <= b;
    // No cycle count is assumed; a missing answer is left to the watchdog
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic chk_to(input int hs, input int fs, input string m);
    chk(32'(hs_to), 32'(HS_BASE_BITS) + 32'(8 * hs), m);
    chk(32'(fs_to), 32'(FS_BASE_TENTHS) + 32'(2 * fs), m);
  endtask

  task automatic t_power_on();
    bus(1'b0, CFG1_OFS, 32'h0, 4'hF, q);
    chk(q, word(3'h5, 3'h3, 2'h0), "image default");
    settle();
    chk_to(5, 3, "timeouts from image");
  endtask

  task automatic t_trim_sweep();
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, CFG1_OFS, word(3'(k), 3'(7 - k), 2'h0), 4'hF, q);
      bus(1'b0, CFG1_OFS, 32'h0, 4'hF, q);
      chk(q, word(3'(k), 3'(7 - k), 2'h0), "trim readback");
      settle();
      chk_to(k, 7 - k, "trimmed timeouts");
      if (k == 0) chk(32'(hs_to >= 10'd736 && hs_to <= 10'd816), 32'h1, "hs base");
      if (k == 0) chk(32'(fs_to >= 8'd160 && fs_to <= 8'd180), 32'h0, "fs trim");
    end
    bus(1'b1, CFG1_OFS, 32'h0, 4'hF, q);
    settle();
    chk(32'(fs_to >= 8'd160 && fs_to <= 8'd180), 32'h1, "fs base");
  endtask

  task automatic t_scale_modes();
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, CFG1_OFS, word(3'h1, 3'h1, 2'(s)), 4'hF, q);
      settle();
      chk(32'(susp_lim), (s & 2) ? SUSP >> 6 : SUSP, "suspend limit");
      chk(32'(gen_lim), (s & 1) ? 32'd1 : 32'd100, "general limit");
    end
    // Leave the core in real timing as normal software would
    bus(1'b1, CFG1_OFS, word(3'h1, 3'h1, 2'h0), 4'hF, q);
  endtask

  task automatic t_lanes_reserved();
    bus(1'b1, CFG1_OFS, 32'hFFFF_FFFF, 4'hF, q);
    bus(1'b0, CFG1_OFS, 32'h0, 4'hF, q);
    chk(q, 32'h0000_E073, "reserved bits");
    bus(1'b1, CFG1_OFS, 32'h0, 4'h2, q);
    bus(1'b0, CFG1_OFS, 32'h0, 4'hF, q);
    chk(q, 32'h0000_0073, "lane one only");
    bus(1'b1, 12'h088, 32'h0, 4'hF, q);
    bus(1'b0, 12'h088, 32'h0, 4'hF, q);
    chk(q, 32'h0, "unmapped read");
    bus(1'b0, CFG1_OFS, 32'h0, 4'hF, q);
    chk(q, 32'h0000_0073, "unmapped write ignored");
  endtask

  task automatic t_restore();
    i_ucal_image_src.load_image(3'h6, 3'h1);
    bus(1'b0, CFG1_OFS, 32'h0, 4'hF, q);
    chk(q, 32'h0000_0073, "load alone keeps trims");
    i_ucal_image_src.pulse_reset(1'b1);
    bus(1'b0, CFG1_OFS, 32'h0, 4'hF, q);
    chk(q, word(3'h6, 3'h1, 2'h3), "lite reset restore");
    settle();
    chk_to(6, 1, "restored timeouts");
    i_ucal_image_src.set_present(1'b0);
    i_ucal_image_src.pulse_reset(1'b0);
    bus(1'b0, CFG1_OFS, 32'h0, 4'hF, q);
    chk(q, word(3'h0, 3'h0, 2'h3), "bus reset no image");
    settle();
    chk_to(0, 0, "cleared timeouts");
  endtask

  // Mid-run reset with the image gone: trims must boot to zero, scale to real timing
  task automatic t_reset_blank();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b0, CFG1_OFS, 32'h0, 4'hF, q);
    chk(q, 32'h0, "power-on without image");
    settle();
    chk_to(0, 0, "untrimmed after reset");
    chk(32'(susp_lim), SUSP, "suspend limit after reset");
    chk(32'(gen_lim), 32'(BUS_RESET_CYCLES), "general limit after reset");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // About 165 cycles of traffic; the 5000-cycle limit leaves ample slack
  initial begin
    #(25 * 5000);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_power_on();
    t_trim_sweep();
    t_scale_modes();
    t_lanes_reserved();
    t_restore();
    t_reset_blank();
    tally_and_finish();
  end
endmodule
`default_nettype wire
